// file: core/mse_pkg.sv
package mse_pkg;

  // Per-input and global mains status codes
  typedef enum logic [1:0] {
    MSE_ABSENT = 2'b00,
    MSE_LOW    = 2'b01,
    MSE_OK     = 2'b10,
    MSE_HIGH   = 2'b11
  } mse_st_type;

  // Controller operating mode
  typedef enum logic [1:0] {
    MSE_MODE_OFF  = 2'b00,
    MSE_MODE_MAN  = 2'b01,
    MSE_MODE_AUTO = 2'b10,
    MSE_MODE_TEST = 2'b11
  } mse_mode_type;

  // Logged event codes
  localparam logic [1:0] EVENT_MAINS_ABSENT           = 2'h1;
  localparam logic [1:0] EVENT_MAINS_OUT_OF_TOLERANCE = 2'h2;
  localparam logic [1:0] EVENT_MAINS_IN_TOLERANCE     = 2'h3;

  // Register byte offsets
  localparam logic [7:0] MSE_REG_CTRL   = 8'h00;
  localparam logic [7:0] MSE_REG_PRES   = 8'h04;
  localparam logic [7:0] MSE_REG_ABS    = 8'h08;
  localparam logic [7:0] MSE_REG_RATED  = 8'h0c;
  localparam logic [7:0] MSE_REG_STATUS = 8'h10;

  // Control field positions
  localparam int MSE_CTRL_SEQ_LSB = 0;  // Required phase sequence, 2 bits
  localparam int MSE_CTRL_3PH     = 2;  // Three-phase mains
  localparam int MSE_CTRL_OPT_LSB = 4;  // Presence delay options, 2 bits
  localparam int MSE_CTRL_EVT_LSB = 6;  // Event log enables, 2 bits
  localparam int MSE_OPT_OFF_BIT  = 0;
  localparam int MSE_OPT_AUTO_BIT = 1;
  localparam int MSE_EVT_MAINS_BIT = 1;

  // Reset values
  localparam logic [7:0]  MSE_CTRL_RST  = 8'h84;
  localparam logic [15:0] MSE_PRES_RST  = 16'h000a;
  localparam logic [15:0] MSE_ABS_RST   = 16'h0005;
  localparam logic [15:0] MSE_RATED_RST = 16'h0190;

endpackage : mse_pkg

// file: core/mse_mains_status_evaluator.sv
`timescale 1ns/100ps
// Summary of operation
// - Phase sequence setting zero skips the rotation check completely.
// - Setting 1 demands clockwise; three-phase counterclockwise marks mains bad.
// - All existing phases and frequency absent gives global absent first.
// - Next, all existing phases and frequency in tolerance gives in tolerance.
// - Next, any existing phase or frequency high gives global high.
// - Otherwise the global status is low.
// - In tolerance with excessive asymmetry is forced to low.
// - In tolerance with wrong rotation is forced to low.
// - External sensor input: inactive defers to the internal sensor, active means in tolerance.
// - Active external sensor forces in tolerance over the internal sensor.
// - Rated voltage zero disables the internal sensor.
// - Off mode skips presence delay unless option bit 0 is set.
// - Auto mode with a generator on load uses the presence delay.
// - Auto mode, no generator, option bit 1 set uses the presence delay.
// - Auto mode, no generator, option bit 1 clear gives zero delay.
// - Changes of event class are logged only while event enable bit 1 is set.
// - Three events: mains absent, out of tolerance, in tolerance.
// - Mains-ok output goes active after in tolerance for the delay.
// - Five flags exported: present, bad, presence run, ok, absence run.
// - Presence delay is waited after return to band before in tolerance.
// - Absence delay is waited with anomaly before declaring mains bad or absent.
module mse_mains_status_evaluator
  import mse_pkg::*;
#(
  parameter int DLY_W = 16
)(
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_TICK,
  // Internal sensor states
  input  wire logic [1:0]  I_V1_ST,
  input  wire logic [1:0]  I_V2_ST,
  input  wire logic [1:0]  I_V3_ST,
  input  wire logic [1:0]  I_FREQ_ST,
  input  wire logic        I_ROT_CW,
  input  wire logic        I_ROT_CCW,
  input  wire logic        I_ASYM_HIGH,
  // External sensor and plant state
  input  wire logic        I_EXT_FN_SEL,
  input  wire logic        I_EXT_SENSOR,
  input  wire logic [1:0]  I_MODE,
  input  wire logic        I_GEN_ON_LOAD,
  input  wire logic        I_OK_FN_SEL,
  // Register port
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  // Status outputs
  output logic      [1:0]  O_STATUS,
  output logic             O_MAINS_OK,
  output logic             O_FLAG_MAINS_PRESENT,
  output logic             O_FLAG_MAINS_BAD_OR_ABSENT,
  output logic             O_FLAG_PRESENCE_DELAY_RUNNING,
  output logic             O_FLAG_MAINS_IN_TOLERANCE,
  output logic             O_FLAG_ABSENCE_DELAY_RUNNING,
  // Event log
  output logic             O_EVT_VALID,
  output logic      [1:0]  O_EVT_CODE
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // True when frequency and every existing phase sit at one state
  function automatic logic all_at(input logic [1:0] v1, input logic [1:0] v2,
                                  input logic [1:0] v3, input logic [1:0] f,
                                  input logic tp, input mse_st_type s);
    all_at = (f == s) && (v1 == s) && (!tp || ((v2 == s) && (v3 == s)));
  endfunction : all_at

  // Event class of a global status
  function automatic logic [1:0] evt_of(input mse_st_type s);
    unique case (s)
      MSE_ABSENT: evt_of = EVENT_MAINS_ABSENT;
      MSE_OK:     evt_of = EVENT_MAINS_IN_TOLERANCE;
      MSE_LOW,
      MSE_HIGH:   evt_of = EVENT_MAINS_OUT_OF_TOLERANCE;
    endcase
  endfunction : evt_of

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]       ctrl_q;
  logic [DLY_W-1:0] pres_dly_q;
  logic [DLY_W-1:0] abs_dly_q;
  logic [15:0]      rated_q;
  mse_st_type       st_q;
  logic             ok_q;
  logic [DLY_W-1:0] cnt_q;
  logic             prun_q;
  logic             arun_q;
  logic             evt_q;
  logic [1:0]       evt_code_q;

  logic [1:0] seq_req;
  logic       tp;
  logic       int_en;
  assign seq_req = ctrl_q[MSE_CTRL_SEQ_LSB +: 2];
  assign tp      = ctrl_q[MSE_CTRL_3PH];
  assign int_en  = (rated_q != 16'h0000);

  // Software writes; delays are in ticks
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      ctrl_q     <= MSE_CTRL_RST;
      pres_dly_q <= DLY_W'(MSE_PRES_RST);
      abs_dly_q  <= DLY_W'(MSE_ABS_RST);
      rated_q    <= MSE_RATED_RST;
    end
    else if (I_WR)
    begin
      unique case (I_ADDR)
        MSE_REG_CTRL:  ctrl_q     <= I_WDATA[7:0];
        MSE_REG_PRES:  pres_dly_q <= I_WDATA[DLY_W-1:0];
        MSE_REG_ABS:   abs_dly_q  <= I_WDATA[DLY_W-1:0];
        MSE_REG_RATED: rated_q    <= I_WDATA[15:0];
        default:       ;
      endcase
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      O_RDATA <= 32'h0000_0000;
    else if (!I_RD)
      O_RDATA <= 32'h0000_0000;
    else
    begin
      unique case (I_ADDR)
        MSE_REG_CTRL:   O_RDATA <= {24'h00_0000, ctrl_q};
        MSE_REG_PRES:   O_RDATA <= 32'(pres_dly_q);
        MSE_REG_ABS:    O_RDATA <= 32'(abs_dly_q);
        MSE_REG_RATED:  O_RDATA <= {16'h0000, rated_q};
        MSE_REG_STATUS: O_RDATA <= {20'h0_0000, evt_code_q, arun_q,
                                    ok_q, prun_q, !ok_q,
                                    (st_q != MSE_ABSENT), ok_q,
                                    2'b00, st_q};
        default:        O_RDATA <= 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instant global status

  logic       all_abs;
  logic       all_ok;
  logic       any_high;
  logic       rot_bad;
  logic       asym_bad;
  mse_st_type raw_st;
  mse_st_type int_st;
  mse_st_type inst_st;

  assign all_abs  = all_at(I_V1_ST, I_V2_ST, I_V3_ST, I_FREQ_ST, tp,
                           MSE_ABSENT);
  assign all_ok   = all_at(I_V1_ST, I_V2_ST, I_V3_ST, I_FREQ_ST, tp,
                           MSE_OK);
  assign any_high = (I_FREQ_ST == MSE_HIGH) || (I_V1_ST == MSE_HIGH) ||
                    (tp && ((I_V2_ST == MSE_HIGH) || (I_V3_ST == MSE_HIGH)));

  // Rotation only matters on three-phase mains; setting zero ignores it
  assign rot_bad  = tp && ((seq_req == 2'h1 && I_ROT_CCW) ||
                           (seq_req == 2'h2 && I_ROT_CW));
  assign asym_bad = tp && I_ASYM_HIGH;

  // Evaluation order: absent, in tolerance, high, then low
  always_comb
  begin
    if (all_abs)
      raw_st = MSE_ABSENT;
    else if (all_ok)
      raw_st = MSE_OK;
    else if (any_high)
      raw_st = MSE_HIGH;
    else
      raw_st = MSE_LOW;
  end

  // Post checks demote in tolerance; disabled sensor never reports presence
  always_comb
  begin
    if (!int_en)
      int_st = MSE_ABSENT;
    else if (raw_st == MSE_OK && (asym_bad || rot_bad))
      int_st = MSE_LOW;
    else
      int_st = raw_st;
  end

  // Active external sensor wins; inactive one defers to the internal sensor
  always_comb
  begin
    if (I_EXT_FN_SEL && I_EXT_SENSOR)
      inst_st = MSE_OK;
    else
      inst_st = int_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Presence and absence delays

  logic             inst_ok;
  logic             mism;
  logic [DLY_W-1:0] pres_eff;
  logic [DLY_W-1:0] tgt;
  logic             done;

  assign inst_ok = (inst_st == MSE_OK);
  assign mism    = (inst_ok != ok_q);

  // Off mode favours quick re-powering of the loads unless told otherwise
  always_comb
  begin
    unique case (mse_mode_type'(I_MODE))
      MSE_MODE_OFF:
        pres_eff = ctrl_q[MSE_CTRL_OPT_LSB + MSE_OPT_OFF_BIT] ?
                   pres_dly_q : '0;
      MSE_MODE_AUTO:
        pres_eff = (I_GEN_ON_LOAD ||
                    ctrl_q[MSE_CTRL_OPT_LSB + MSE_OPT_AUTO_BIT]) ?
                   pres_dly_q : '0;
      MSE_MODE_MAN,
      MSE_MODE_TEST:
        pres_eff = pres_dly_q;
    endcase
  end

  assign tgt  = ok_q ? abs_dly_q : pres_eff;
  // Zero and one both flip on the first mismatched tick
  assign done = ({1'b0, cnt_q} + {{DLY_W{1'b0}}, 1'b1}) >= {1'b0, tgt};

  // Delay timer restarts whenever the instant state agrees again
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      ok_q   <= 1'b0;
      cnt_q  <= '0;
      prun_q <= 1'b0;
      arun_q <= 1'b0;
    end
    else if (I_TICK)
    begin
      if (mism && done)
      begin
        ok_q  <= inst_ok;
        cnt_q <= '0;
      end
      else if (mism)
        cnt_q <= cnt_q + 1'b1;
      else
        cnt_q <= '0;
      prun_q <= mism && !done && inst_ok;
      arun_q <= mism && !done && !inst_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register and event log

  // Status is sampled once per tick
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      st_q <= MSE_ABSENT;
    else if (I_TICK)
      st_q <= inst_st;
  end

  // One pulse per change of event class while logging is enabled
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      evt_q      <= 1'b0;
      evt_code_q <= 2'h0;
    end
    else
    begin
      evt_q <= I_TICK && ctrl_q[MSE_CTRL_EVT_LSB + MSE_EVT_MAINS_BIT] &&
               (evt_of(inst_st) != evt_of(st_q));
      if (I_TICK && (evt_of(inst_st) != evt_of(st_q)))
        evt_code_q <= evt_of(inst_st);
    end
  end

  // Outputs are decoded from flops; mains ok is also gated by I_OK_FN_SEL
  assign O_STATUS                      = st_q;
  assign O_MAINS_OK                    = ok_q && I_OK_FN_SEL;
  assign O_FLAG_MAINS_PRESENT          = (st_q != MSE_ABSENT);
  assign O_FLAG_MAINS_BAD_OR_ABSENT    = !ok_q;
  assign O_FLAG_PRESENCE_DELAY_RUNNING = prun_q;
  assign O_FLAG_MAINS_IN_TOLERANCE     = ok_q;
  assign O_FLAG_ABSENCE_DELAY_RUNNING  = arun_q;
  assign O_EVT_VALID                   = evt_q;
  assign O_EVT_CODE                    = evt_code_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);

  sequence s_tick_int;
    I_TICK && !I_EXT_FN_SEL && int_en;
  endsequence

  sequence s_ok_arrives;
    I_TICK && inst_ok && !ok_q && done;
  endsequence

  a_rot_skip: assert property (
    s_tick_int ##0 (seq_req == 2'h0 && all_ok && !asym_bad) |=>
    st_q == MSE_OK) else $error("rotation not skipped");

  a_rot_cw_req: assert property (
    s_tick_int ##0 (tp && seq_req == 2'h1 && I_ROT_CCW) |=>
    st_q != MSE_OK) else $error("ccw accepted");

  a_rot_ccw_req: assert property (
    s_tick_int ##0 (tp && seq_req == 2'h2 && I_ROT_CW) |=>
    st_q != MSE_OK) else $error("cw accepted");

  a_absent_first: assert property (
    s_tick_int ##0 all_abs |=> st_q == MSE_ABSENT)
    else $error("absent not first");

  a_high_over_low: assert property (
    s_tick_int ##0 (!all_abs && any_high) |=> st_q == MSE_HIGH)
    else $error("high not reported");

  a_ext_force: assert property (
    I_TICK && I_EXT_FN_SEL && I_EXT_SENSOR |=> st_q == MSE_OK)
    else $error("external sensor ignored");

  a_sensor_off: assert property (
    I_TICK && !I_EXT_FN_SEL && rated_q == 16'h0000 |=> st_q == MSE_ABSENT)
    else $error("disabled sensor reported");

  a_off_no_delay: assert property (
    I_TICK && I_MODE == MSE_MODE_OFF && !ctrl_q[MSE_CTRL_OPT_LSB] &&
    inst_ok && !ok_q |=> ok_q) else $error("off mode delayed");

  a_ok_after_dly: assert property (
    s_ok_arrives ##1 I_OK_FN_SEL |-> O_MAINS_OK && !prun_q)
    else $error("mains ok late");

  a_evt_gate: assert property (
    O_EVT_VALID |-> $past(ctrl_q[MSE_CTRL_EVT_LSB + 1]) && $past(I_TICK))
    else $error("event not gated");

  a_ok_second: assert property (
    s_tick_int ##0 (!all_abs && all_ok && !rot_bad && !asym_bad) |=>
    st_q == MSE_OK) else $error("in tolerance lost");

  a_asym_low: assert property (
    s_tick_int ##0 (all_ok && asym_bad) |=> st_q == MSE_LOW)
    else $error("asymmetry ignored");

  a_auto_no_dly: assert property (
    I_TICK && I_MODE == MSE_MODE_AUTO && !I_GEN_ON_LOAD &&
    !ctrl_q[MSE_CTRL_OPT_LSB + MSE_OPT_AUTO_BIT] &&
    inst_ok && !ok_q |=> ok_q) else $error("auto mode delayed");

  a_abs_wait: assert property (
    I_TICK && ok_q && !inst_ok && !done |=> ok_q && arun_q)
    else $error("absence not delayed");

endmodule : mse_mains_status_evaluator

// file: sim/mse_front_end_model.sv
`timescale 1ns/100ps
////////////////////////////////////////
// Mains measurement front end seen by the evaluator
module mse_front_end_model
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // Requested states {v1, v2, v3, freq, cw, ccw, asym}
  input  wire logic [10:0] i_meas,
  // Sensor states
  output logic      [10:0] o_meas
);
  // Settles one edge late, as a sampled front end would, so the
  // evaluator never sees a request in the cycle it is made
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_meas <= 11'h000;
    else
      o_meas <= i_meas;
  end
endmodule : mse_front_end_model

// file: sim/mse_mains_status_evaluator_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, a) \
  begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
////////////////////////////////////////
module mse_mains_status_evaluator_tb;
  import mse_pkg::*;
  // Status row: control byte, measurement, expected status
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [10:0] meas;
    mse_st_type  st;
  } mse_row_type;
  // Delay row: mode, generator, control byte, delay expected
  typedef struct packed {
    mse_mode_type mode;
    logic         gen;
    logic [7:0]   ctrl;
    logic         wait_on;
  } mse_dly_type;
  logic        I_CLK = 1'b0;
  logic        I_ARST_N = 1'b0;
  logic        I_TICK = 1'b0;
  logic        I_EXT_FN_SEL = 1'b0;
  logic        I_EXT_SENSOR = 1'b0;
  logic [1:0]  I_MODE = 2'h2;
  logic        I_GEN_ON_LOAD = 1'b0;
  logic        I_OK_FN_SEL = 1'b1;
  logic [7:0]  I_ADDR = 8'h00;
  logic [31:0] I_WDATA = 32'h0;
  logic        I_WR = 1'b0;
  logic        I_RD = 1'b0;
  logic [10:0] meas = 11'h000;
  logic [10:0] sens;
  logic [31:0] O_RDATA;
  logic [1:0]  O_STATUS;
  logic [1:0]  O_EVT_CODE;
  logic        O_EVT_VALID;
  logic        O_MAINS_OK;
  logic        f_pres;
  logic        f_bad;
  logic        f_prun;
  logic        f_ok;
  logic        f_arun;
  int          errors = 0;
  int          n_checks = 0;
  mse_row_type rows [11] = '{
    '{8'h04, 11'h000, MSE_ABSENT},  // All absent
    '{8'h04, 11'h552, MSE_OK},      // No rotation demand
    '{8'h04, 11'h5d0, MSE_HIGH},    // Phase 2 high
    '{8'h04, 11'h548, MSE_LOW},     // Frequency low
    '{8'h04, 11'h551, MSE_LOW},     // Asymmetry
    '{8'h05, 11'h552, MSE_LOW},     // Clockwise demanded
    '{8'h06, 11'h554, MSE_LOW},     // Counterclockwise demanded
    '{8'h05, 11'h554, MSE_OK},      // Rotation matches
    '{8'h00, 11'h410, MSE_OK},      // Single phase ignores 2 and 3
    '{8'h00, 11'h218, MSE_HIGH},    // Frequency high
    '{8'h00, 11'h010, MSE_LOW}};    // Phase absent only
  mse_dly_type dl [7] = '{
    '{MSE_MODE_OFF, 1'b0, 8'h04, 1'b0},
    '{MSE_MODE_OFF, 1'b0, 8'h14, 1'b1},
    '{MSE_MODE_AUTO, 1'b1, 8'h04, 1'b1},
    '{MSE_MODE_AUTO, 1'b0, 8'h24, 1'b1},
    '{MSE_MODE_AUTO, 1'b0, 8'h04, 1'b0},
    '{MSE_MODE_MAN, 1'b0, 8'h04, 1'b1},
    '{MSE_MODE_TEST, 1'b0, 8'h04, 1'b1}};
  logic [10:0] ev_meas [4] = '{11'h550, 11'h548, 11'h000, 11'h550};
  logic [1:0]  ev_code [4] = '{EVENT_MAINS_IN_TOLERANCE,
    EVENT_MAINS_OUT_OF_TOLERANCE, EVENT_MAINS_ABSENT,
    EVENT_MAINS_IN_TOLERANCE};

  always #10 I_CLK = ~I_CLK;

  mse_front_end_model model (.i_clk(I_CLK), .i_arst_n(I_ARST_N),
    .i_meas(meas), .o_meas(sens));

  mse_mains_status_evaluator uut (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
    .I_TICK(I_TICK), .I_V1_ST(sens[10:9]), .I_V2_ST(sens[8:7]),
    .I_V3_ST(sens[6:5]), .I_FREQ_ST(sens[4:3]), .I_ROT_CW(sens[2]),
    .I_ROT_CCW(sens[1]), .I_ASYM_HIGH(sens[0]),
    .I_EXT_FN_SEL(I_EXT_FN_SEL), .I_EXT_SENSOR(I_EXT_SENSOR),
    .I_MODE(I_MODE), .I_GEN_ON_LOAD(I_GEN_ON_LOAD),
    .I_OK_FN_SEL(I_OK_FN_SEL), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_STATUS(O_STATUS),
    .O_MAINS_OK(O_MAINS_OK), .O_FLAG_MAINS_PRESENT(f_pres),
    .O_FLAG_MAINS_BAD_OR_ABSENT(f_bad),
    .O_FLAG_PRESENCE_DELAY_RUNNING(f_prun),
    .O_FLAG_MAINS_IN_TOLERANCE(f_ok),
    .O_FLAG_ABSENCE_DELAY_RUNNING(f_arun),
    .O_EVT_VALID(O_EVT_VALID), .O_EVT_CODE(O_EVT_CODE));

  ////////////////////////////////////////
  // Bus, measurement and tick drivers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask : wr

  // Read data live only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge I_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1;
    `CHK("rdata", e, O_RDATA)
    @(posedge I_CLK);
    #1;
    `CHK("rdata idle", 32'h0, O_RDATA)
  endtask : rd

  // Two edges so the front end has settled before the next tick
  task automatic put(input logic [10:0] m);
    @(posedge I_CLK);
    meas <= m;
    @(posedge I_CLK);
  endtask : put

  task automatic tick();
    @(posedge I_CLK);
    I_TICK <= 1'b1;
    @(posedge I_CLK);
    I_TICK <= 1'b0;
    #1;
  endtask : tick

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (6) @(posedge I_CLK);
    I_ARST_N <= 1'b1;
    #1;
    `CHK("status", MSE_ABSENT, O_STATUS)
    `CHK("bad", 1'b1, f_bad)
    `CHK("ok rst", 1'b0, O_MAINS_OK)
    rd(MSE_REG_CTRL, {24'h0, MSE_CTRL_RST});
    rd(MSE_REG_PRES, {16'h0, MSE_PRES_RST});
    rd(MSE_REG_ABS, {16'h0, MSE_ABS_RST});
    rd(MSE_REG_RATED, {16'h0, MSE_RATED_RST});
    rd(8'h14, 32'h0);
    wr(MSE_REG_ABS, 32'h1);
    foreach (rows[i])
    begin
      wr(MSE_REG_CTRL, {24'h0, rows[i].ctrl});
      put(rows[i].meas);
      tick();
      `CHK("status", rows[i].st, O_STATUS)
      `CHK("status again", rows[i].st, O_STATUS)
    end
    // Events, logged, then with logging off
    wr(MSE_REG_CTRL, 32'h84);
    foreach (ev_meas[i])
    begin
      put(ev_meas[i]);
      tick();
      `CHK("evt valid", 1'b1, O_EVT_VALID)
      `CHK("evt code", ev_code[i], O_EVT_CODE)
      @(posedge I_CLK);
      #1;
      `CHK("evt pulse", 1'b0, O_EVT_VALID)
    end
    wr(MSE_REG_CTRL, 32'h04);
    put(11'h000);
    tick();
    `CHK("evt off", 1'b0, O_EVT_VALID)
    // External sensor over an internal high reading
    put(11'h5d0);
    I_EXT_FN_SEL <= 1'b1;
    I_EXT_SENSOR <= 1'b1;
    tick();
    `CHK("ext on", MSE_OK, O_STATUS)
    wr(MSE_REG_RATED, 32'h0);
    I_EXT_SENSOR <= 1'b0;
    tick();
    `CHK("ext off", MSE_ABSENT, O_STATUS)
    @(posedge I_CLK);
    I_EXT_SENSOR <= 1'b1;
    tick();
    `CHK("ext on", MSE_OK, O_STATUS)
    wr(MSE_REG_RATED, {16'h0, MSE_RATED_RST});
    I_EXT_FN_SEL <= 1'b0;
    // Presence delay per mode, generator and option
    wr(MSE_REG_PRES, 32'h3);
    foreach (dl[i])
    begin
      wr(MSE_REG_CTRL, {24'h0, dl[i].ctrl});
      put(11'h000);
      I_MODE <= dl[i].mode;
      I_GEN_ON_LOAD <= dl[i].gen;
      tick();
      put(11'h550);
      tick();
      if (dl[i].wait_on)
      begin
        `CHK("ok early", 1'b0, O_MAINS_OK)
        `CHK("pres run", 1'b1, f_prun)
        tick();
        tick();
      end
      `CHK("ok", 1'b1, O_MAINS_OK)
      `CHK("in tol", 1'b1, f_ok)
      `CHK("present", 1'b1, f_pres)
      `CHK("bad", 1'b0, f_bad)
    end
    // An output without the mains-ok function stays inactive
    @(posedge I_CLK);
    I_OK_FN_SEL <= 1'b0;
    @(posedge I_CLK);
    #1;
    `CHK("ok unsel", 1'b0, O_MAINS_OK)
    `CHK("ok flag", 1'b1, f_ok)
    @(posedge I_CLK);
    I_OK_FN_SEL <= 1'b1;
    // Absence delay of three holds the good state for two ticks, drops it on the third
    wr(MSE_REG_ABS, 32'h3);
    put(11'h548);
    tick();
    `CHK("abs run", 1'b1, f_arun)
    `CHK("ok held", 1'b1, f_ok)
    tick();
    tick();
    `CHK("ok gone", 1'b0, f_ok)
    `CHK("bad", 1'b1, f_bad)
    `CHK("abs done", 1'b0, f_arun)
    // Low status, present, bad, last event out of tolerance
    rd(MSE_REG_STATUS, 32'h0000_0861);
    // Second reset in mid-run
    @(posedge I_CLK);
    I_ARST_N <= 1'b0;
    @(posedge I_CLK);
    I_ARST_N <= 1'b1;
    #1;
    `CHK("status", MSE_ABSENT, O_STATUS)
    `CHK("bad", 1'b1, f_bad)
    `CHK("present", 1'b0, f_pres)
    rd(MSE_REG_ABS, {16'h0, MSE_ABS_RST});
    test_done();
  end

  // Tests need well under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge I_CLK);
    errors++;
    test_done();
  end
endmodule : mse_mains_status_evaluator_tb
